// ### ccam_interp.sv
// Conditional call and accumulator move slice of the command interpreter
`timescale 1ns/1ps
`include "ccam_params.svh"
module ccam_interp import ccam_pkg::*; #(
  parameter int PC_W = 32,
  parameter int AXES = `CCAM_AXIS_COUNT
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Command from decoder
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [7:0] cmd_type_in,
  input wire logic [7:0] cmd_axis_in,
  input wire logic [31:0] cmd_value_in,
  // Program counter of the running program (points at next instruction)
  input wire logic [PC_W-1:0] pc_in,
  output logic pc_load_out,
  output logic [PC_W-1:0] pc_value_out,
  // Flags from latest compare or assignment, and error flags
  input wire logic flag_zero_in,
  input wire logic flag_greater_in,
  input wire logic flag_lower_in,
  input wire logic flag_timeout_in,
  input wire logic flag_alarm_in,
  input wire logic flag_deviation_in,
  input wire logic flag_position_err_in,
  // Accumulator and actual positions
  input wire logic [31:0] accum_in,
  input wire logic [AXES-1:0][31:0] actual_pos_in,
  // Stored coordinate lookup
  output logic move_type_stored_coordinate_req_out,
  output logic [7:0] move_type_stored_coordinate_index_out,
  input wire logic move_type_stored_coordinate_ack_in,
  input wire logic [31:0] move_type_stored_coordinate_data_in,
  // Axis parameter write to motion controller
  output logic param_wr_out,
  output logic [7:0] param_axis_out,
  output logic [7:0] param_num_out,
  output logic [31:0] param_data_out,
  output logic [AXES-1:0] move_active_out,
  input wire logic [AXES-1:0] move_done_in,
  // Reply
  output logic reply_valid_out,
  output logic [7:0] reply_status_out,
  output logic [7:0] reply_opcode_out,
  // Interpreter reset request on restart
  output logic regs_clear_out
);
  typedef struct packed {
    ccam_state_e state;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic move_type_stored_coordinate_req;
    logic [7:0] move_type_stored_coordinate_index;
    logic param_wr;
    logic [7:0] param_axis;
    logic [31:0] param_data;
    logic [AXES-1:0] active;
    logic reply_valid;
    logic [7:0] reply_status;
    logic [7:0] reply_opcode;
    logic regs_clear;
  } ccam_int_s;
  ccam_int_s st;
  ccam_int_s next_st;

  logic stk_push;
  logic stk_pop;
  logic stk_clear;
  logic stk_full;
  logic stk_empty;
  logic [PC_W-1:0] stk_top;
  logic cond_met;
  logic take;
  logic axis_ok;
  logic [2:0] axis_idx;

  ccam_return_stack #(.DEPTH(`CCAM_STACK_DEPTH), .PC_W(PC_W)) u_stack (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .push_in(stk_push),
    .pop_in(stk_pop),
    .clear_in(stk_clear),
    .push_data_in(pc_in),
    .top_out(stk_top),
    .full_out(stk_full),
    .empty_out(stk_empty)
  );

  // Ready only while idle; a move occupies the slice for the reply cycle, a stored coordinate move also until its lookup ack
  assign cmd_ready_out = (st.state == CCAM_IDLE);
  assign take = cmd_valid_in && cmd_ready_out;
  assign axis_ok = (cmd_axis_in < 8'(AXES));
  assign axis_idx = cmd_axis_in[2:0];

  always_comb begin
    case (ccam_cond_e'(cmd_type_in[3:0]))
      cond_zero: cond_met = flag_zero_in;
      cond_not_zero: cond_met = !flag_zero_in;
      cond_equal: cond_met = flag_zero_in;
      cond_not_equal: cond_met = !flag_zero_in;
      cond_greater: cond_met = flag_greater_in;
      cond_greater_equal: cond_met = flag_greater_in || flag_zero_in;
      cond_lower: cond_met = flag_lower_in;
      cond_lower_equal: cond_met = flag_lower_in || flag_zero_in;
      cond_timeout_error: cond_met = flag_timeout_in;
      cond_external_alarm: cond_met = flag_alarm_in;
      cond_deviation_error: cond_met = flag_deviation_in;
      cond_position_error: cond_met = flag_position_err_in;
      default: cond_met = 1'b0;
    endcase
    if (cmd_type_in > 8'(`CCAM_COND_LAST)) begin
      cond_met = 1'b0;
    end
  end

  always_comb begin
    next_st = st;
    next_st.pc_load = 1'b0;
    next_st.param_wr = 1'b0;
    next_st.reply_valid = 1'b0;
    next_st.regs_clear = 1'b0;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    stk_clear = 1'b0;
    // Completion from the motion controller clears the busy marks
    next_st.active = st.active & ~move_done_in;
    case (st.state)
      CCAM_IDLE: begin
        if (take) begin
          next_st.reply_opcode = cmd_opcode_in;
          next_st.reply_status = `CCAM_STATUS_OK;
          case (cmd_opcode_in)
            `CCAM_OP_COND_CALL: begin
              if (cond_met && !stk_full) begin
                stk_push = 1'b1;
                next_st.pc_load = 1'b1;
                next_st.pc_value = cmd_value_in[PC_W-1:0];
              end
              next_st.state = CCAM_REPLY;
            end
            `CCAM_OP_MOVE_ACC: begin
              if (cmd_type_in > `CCAM_MOVE_LAST) begin
                next_st.reply_status = `CCAM_STATUS_BAD_TYPE;
                next_st.state = CCAM_REPLY;
              end else if (cmd_type_in[1:0] == move_type_stored_coordinate) begin
                next_st.move_type_stored_coordinate_req = 1'b1;
                next_st.move_type_stored_coordinate_index = cmd_axis_in;
                next_st.param_axis = 8'h00;
                next_st.state = CCAM_MOVE_TYPE_STORED_COORDINATE_WAIT;
              end else if (!axis_ok) begin
                next_st.reply_status = `CCAM_STATUS_BAD_VALUE;
                next_st.state = CCAM_REPLY;
              end else begin
                next_st.param_wr = 1'b1;
                next_st.param_axis = cmd_axis_in;
                next_st.param_data = (cmd_type_in[1:0] == move_type_relative) ?
                  actual_pos_in[axis_idx] + accum_in : accum_in;
                next_st.active[axis_idx] = 1'b1;
                next_st.state = CCAM_REPLY;
              end
            end
            `CCAM_OP_MOTOR_HALT, `CCAM_OP_ROTATE_LEFT, `CCAM_OP_ROTATE_RIGHT: begin
              if (axis_ok) begin
                next_st.active[axis_idx] = 1'b0;
              end
              next_st.state = CCAM_REPLY;
            end
            `CCAM_OP_SUB_RETURN: begin
              if (!stk_empty) begin
                stk_pop = 1'b1;
                next_st.pc_load = 1'b1;
                next_st.pc_value = stk_top;
              end
              next_st.state = CCAM_REPLY;
            end
            `CCAM_OP_RESTART: begin
              stk_clear = 1'b1;
              next_st.regs_clear = 1'b1;
              next_st.pc_load = 1'b1;
              next_st.pc_value = cmd_value_in[PC_W-1:0];
              next_st.state = CCAM_REPLY;
            end
            default: begin
              next_st.reply_status = `CCAM_STATUS_BAD_CMD;
              next_st.state = CCAM_REPLY;
            end
          endcase
        end
      end
      CCAM_MOVE_TYPE_STORED_COORDINATE_WAIT: begin
        if (move_type_stored_coordinate_ack_in) begin
          next_st.move_type_stored_coordinate_req = 1'b0;
          next_st.param_wr = 1'b1;
          next_st.param_data = move_type_stored_coordinate_data_in;
          next_st.active[st.param_axis[2:0]] = 1'b1;
          next_st.state = CCAM_REPLY;
        end
      end
      CCAM_REPLY: begin
        next_st.reply_valid = 1'b1;
        next_st.state = CCAM_IDLE;
      end
      default: begin
        next_st.state = CCAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pc_load_out = st.pc_load;
  assign pc_value_out = st.pc_value;
  assign move_type_stored_coordinate_req_out = st.move_type_stored_coordinate_req;
  assign move_type_stored_coordinate_index_out = st.move_type_stored_coordinate_index;
  assign param_wr_out = st.param_wr;
  assign param_axis_out = st.param_axis;
  assign param_num_out = `CCAM_PARAM_TARGET_POS;
  assign param_data_out = st.param_data;
  assign move_active_out = st.active;
  assign reply_valid_out = st.reply_valid;
  assign reply_status_out = st.reply_status;
  assign reply_opcode_out = st.reply_opcode;
  assign regs_clear_out = st.regs_clear;
endmodule

// ### ccam_interp_bench.sv
// Self-checking bench for the call and accumulator move slice
`timescale 1ns/1ps
`include "ccam_params.svh"
module ccam_interp_bench import ccam_pkg::*; ;
  logic clk = 0, rst = 1, valid = 0, slow = 0;
  logic [7:0] op = 0, typ = 0, axis = 0;
  logic [31:0] val = 0, pc = 0, accum = 0;
  logic [6:0] flags = 0;
  logic [5:0][31:0] act = 0;
  wire ready, pc_load, param_wr, reply_valid, creq, cack, clr;
  wire [31:0] pc_value, param_data, cdata;
  wire [7:0] cidx, param_axis, param_num, status, ropc;
  wire [5:0] active;
  int bad_count = 0, checked = 0;
  logic [31:0] stk[$], exp_pc[$];
  logic [39:0] exp_par[$];
  logic [15:0] exp_rep[$];
  ccam_interp #(.PC_W(32), .AXES(6)) i_dut (
    .clk_sys_in(clk), .sys_rst_in(rst), .cmd_valid_in(valid), .cmd_ready_out(ready),
    .cmd_opcode_in(op), .cmd_type_in(typ), .cmd_axis_in(axis), .cmd_value_in(val),
    .pc_in(pc), .pc_load_out(pc_load), .pc_value_out(pc_value),
    .flag_zero_in(flags[0]), .flag_greater_in(flags[1]), .flag_lower_in(flags[2]),
    .flag_timeout_in(flags[3]), .flag_alarm_in(flags[4]), .flag_deviation_in(flags[5]),
    .flag_position_err_in(flags[6]), .accum_in(accum), .actual_pos_in(act),
    .move_type_stored_coordinate_req_out(creq), .move_type_stored_coordinate_index_out(cidx), .move_type_stored_coordinate_ack_in(cack), .move_type_stored_coordinate_data_in(cdata),
    .param_wr_out(param_wr), .param_axis_out(param_axis), .param_num_out(param_num),
    .param_data_out(param_data), .move_active_out(active), .move_done_in(6'h00),
    .reply_valid_out(reply_valid), .reply_status_out(status), .reply_opcode_out(ropc),
    .regs_clear_out(clr));
  ccam_move_type_stored_coordinate_model i_move_type_stored_coordinate (.clk_sys_in(clk), .sys_rst_in(rst), .slow_in(slow),
    .req_in(creq), .index_in(cidx), .ack_out(cack), .data_out(cdata));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reply(input logic [15:0] got, input logic [15:0] exp);
    chk(40'(got), 40'(exp));
  endtask
  task automatic chk_param(input logic [39:0] got, input logic [39:0] exp);
    chk(got, exp);
  endtask
  task automatic chk_pc(input logic [31:0] got, input logic [31:0] exp);
    chk(40'(got), 40'(exp));
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic cond(input logic [3:0] c);
    case (c)
      0, 2: return flags[0];
      1, 3: return !flags[0];
      4: return flags[1];
      5: return flags[1] | flags[0];
      6: return flags[2];
      7: return flags[2] | flags[0];
      default: return flags[c - 4'h5];
    endcase
  endfunction
  // Entered and left just after an edge with ready high; every answer must be in by then
  task automatic issue(input logic [7:0] o, t, a, input logic [31:0] v);
    op = o;
    typ = t;
    axis = a;
    val = v;
    valid = 1;
    @(posedge clk);
    #2 valid = 0;
    for (int n = 0; !ready; n++) begin
      if (n > 40) begin
        bad_count++;
        test_done;
      end
      @(posedge clk);
      #2;
    end
    chk(40'(exp_pc.size() + exp_par.size() + exp_rep.size()), 40'h0);
  endtask
  task automatic call(input logic [3:0] c, input logic [31:0] dst);
    pc = $urandom;
    if (cond(c) && stk.size() < 8) begin
      stk.push_back(pc);
      exp_pc.push_back(dst);
    end
    exp_rep.push_back({`CCAM_OP_COND_CALL, `CCAM_STATUS_OK});
    issue(`CCAM_OP_COND_CALL, {4'h0, c}, 8'h00, dst);
  endtask
  task automatic ret;
    if (stk.size() > 0)
      exp_pc.push_back(stk.pop_back());
    exp_rep.push_back({`CCAM_OP_SUB_RETURN, `CCAM_STATUS_OK});
    issue(`CCAM_OP_SUB_RETURN, 8'h00, 8'h00, 32'h0);
  endtask
  task automatic move(input logic [7:0] t, a, st);
    accum = $urandom;
    if (st == `CCAM_STATUS_OK)
      exp_par.push_back(t == 2 ? {8'h00, 32'hC0DE_0000 | 32'(a)}
        : {a, t[0] ? accum + act[a] : accum});
    exp_rep.push_back({`CCAM_OP_MOVE_ACC, st});
    issue(`CCAM_OP_MOVE_ACC, t, a, $urandom);
  endtask
  // Results are matched in order of arrival against what the driver noted
  always @(posedge clk) begin
    #1;
    if (reply_valid && exp_rep.size() > 0) chk_reply({ropc, status}, exp_rep.pop_front());
    if (param_wr && exp_par.size() > 0)
      chk_param({param_axis, param_data}, exp_par.pop_front());
    if (param_wr) chk(40'(param_num), 40'(`CCAM_PARAM_TARGET_POS));
    if (pc_load && exp_pc.size() > 0) chk_pc(pc_value, exp_pc.pop_front());
    else if (pc_load && op != `CCAM_OP_RESTART) chk(40'h1, 40'h0);
    if (clr) chk(40'(op), 40'(`CCAM_OP_RESTART));
  end
  initial begin
    accum = $urandom(50);
    repeat (6) @(posedge clk);
    #2 rst = 0;
    @(posedge clk);
    #2;
    for (int i = 0; i < 24; i++) begin
      flags = $urandom;
      call(4'(i % 12), $urandom);
      ret;
    end
    flags = 7'h08;
    repeat (9) call(4'h8, $urandom);
    repeat (9) ret;
    repeat (2) call(4'h8, $urandom);
    exp_rep.push_back({`CCAM_OP_RESTART, `CCAM_STATUS_OK});
    exp_pc.push_back(32'h10);
    issue(`CCAM_OP_RESTART, 8'h00, 8'h00, 32'h10);
    stk.delete();
    ret;
    foreach (act[k]) act[k] = $urandom;
    act[3] = 32'h7FFF_FFF0;
    for (int i = 0; i < 12; i++) move(8'(i % 2), 8'(i % 6), `CCAM_STATUS_OK);
    for (int k = 1; k < 4; k++) begin
      move(8'h00, 8'(k), `CCAM_STATUS_OK);
      chk(40'(active[k]), 40'h1);
      exp_rep.push_back({8'(k), `CCAM_STATUS_OK});
      issue(8'(k), 8'h00, 8'(k), 32'h0);
      chk(40'(active[k]), 40'h0);
    end
    move(8'h02, 8'hFF, `CCAM_STATUS_OK);
    slow = 1;
    move(8'h02, 8'h07, `CCAM_STATUS_OK);
    move(8'h03, 8'h00, `CCAM_STATUS_BAD_TYPE);
    move(8'h00, 8'h06, `CCAM_STATUS_BAD_VALUE);
    exp_rep.push_back({8'h99, `CCAM_STATUS_BAD_CMD});
    issue(8'h99, 8'h00, 8'h00, 32'h0);
    test_done;
  end
endmodule

// ### ccam_interp_checker.sv
// Port assertions for the call and accumulator move slice
`timescale 1ns/1ps
`include "ccam_params.svh"
module ccam_interp_checker import ccam_pkg::*; #(
  parameter int PC_W = 32,
  parameter int AXES = `CCAM_AXIS_COUNT
) (
  // Clock, reset and command
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [7:0] cmd_type_in,
  input wire logic [7:0] cmd_axis_in,
  input wire logic [31:0] cmd_value_in,
  input wire logic flag_zero_in,
  input wire logic [31:0] accum_in,
  input wire logic [AXES-1:0][31:0] actual_pos_in,
  input wire logic move_type_stored_coordinate_ack_in,
  input wire logic [31:0] move_type_stored_coordinate_data_in,
  // Results
  input wire logic move_type_stored_coordinate_req_out,
  input wire logic pc_load_out,
  input wire logic [PC_W-1:0] pc_value_out,
  input wire logic param_wr_out,
  input wire logic [7:0] param_num_out,
  input wire logic [31:0] param_data_out,
  input wire logic [AXES-1:0] move_active_out,
  input wire logic reply_valid_out,
  input wire logic [7:0] reply_status_out,
  input wire logic regs_clear_out
);
  wire take = cmd_valid_in && cmd_ready_out;
  wire call = take && cmd_opcode_in == `CCAM_OP_COND_CALL;
  wire mv = take && cmd_opcode_in == `CCAM_OP_MOVE_ACC && cmd_axis_in < AXES;
  wire stop = take && cmd_opcode_in inside {8'h01, 8'h02, 8'h03} && cmd_axis_in < AXES;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  a_call_pc_load: assert property (call |=> pc_load_out |->
    pc_value_out == $past(cmd_value_in)) else $error("call loaded a wrong pc");
  a_call_skip: assert property (call && cmd_type_in == 8'h00 && !flag_zero_in
    |=> !pc_load_out) else $error("untaken call loaded the pc");
  // Ready is back in the reply cycle itself, so a new command may be taken there
  a_call_reply: assert property (call |=> !cmd_ready_out ##1
    reply_valid_out && reply_status_out == `CCAM_STATUS_OK && cmd_ready_out)
    else $error("call reply out of step");
  a_target_param: assert property (param_wr_out |->
    param_num_out == `CCAM_PARAM_TARGET_POS) else $error("move wrote a wrong parameter");
  a_abs_target: assert property (mv && cmd_type_in == 8'h00 |=> param_wr_out &&
    param_data_out == $past(accum_in) && move_active_out[$past(cmd_axis_in)])
    else $error("absolute move target wrong");
  a_rel_wrap: assert property (mv && cmd_type_in == 8'h01 |=> param_wr_out &&
    param_data_out == $past(accum_in) + $past(actual_pos_in[cmd_axis_in]))
    else $error("relative move target wrong");
  a_move_type_stored_coordinate_fetch: assert property (take && cmd_opcode_in == `CCAM_OP_MOVE_ACC &&
    cmd_type_in == 8'h02 |=> move_type_stored_coordinate_req_out) else $error("no coordinate lookup");
  a_move_type_stored_coordinate_write: assert property (move_type_stored_coordinate_req_out && move_type_stored_coordinate_ack_in |=> param_wr_out &&
    param_data_out == $past(move_type_stored_coordinate_data_in) ##1 reply_valid_out)
    else $error("stored coordinate not written");
  a_stop_abort: assert property (stop |=>
    !move_active_out[$past(cmd_axis_in)]) else $error("move not aborted");
  a_restart_clear: assert property (take && cmd_opcode_in == `CCAM_OP_RESTART
    |=> regs_clear_out) else $error("restart did not clear");
endmodule
bind ccam_interp ccam_interp_checker #(.PC_W(PC_W), .AXES(AXES)) i_chk (.*);

// ### ccam_move_type_stored_coordinate_model.sv
// Stored coordinate table answering lookups promptly or slowly
`timescale 1ns/1ps
module ccam_move_type_stored_coordinate_model (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic slow_in,
  input wire logic req_in,
  input wire logic [7:0] index_in,
  output logic ack_out,
  output logic [31:0] data_out
);
  logic [3:0] wait_cnt;
  // stored coordinate lookup; data toggles outside the ack so stale values show
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_cnt <= 4'h0;
      ack_out <= 1'b0;
      data_out <= 32'h0;
    end else begin
      ack_out <= 1'b0;
      data_out <= ~data_out;
      if (req_in && !ack_out) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= (slow_in ? 4'h6 : 4'h0)) begin
          ack_out <= 1'b1;
          data_out <= 32'hC0DE_0000 | 32'(index_in);
          wait_cnt <= 4'h0;
        end
      end
    end
  end
endmodule

// ### ccam_params.svh
// Constants for the conditional call and accumulator move interpreter slice
`ifndef CCAM_PARAMS_SVH
`define CCAM_PARAMS_SVH
`define CCAM_OP_COND_CALL 8'h15
`define CCAM_OP_MOVE_ACC 8'h2E
`define CCAM_OP_ROTATE_RIGHT 8'h01
`define CCAM_OP_ROTATE_LEFT 8'h02
`define CCAM_OP_MOTOR_HALT 8'h03
`define CCAM_OP_SUB_RETURN 8'h17
`define CCAM_OP_RESTART 8'h30
`define CCAM_STATUS_OK 8'h64
`define CCAM_STATUS_BAD_TYPE 8'h03
`define CCAM_STATUS_BAD_VALUE 8'h04
`define CCAM_STATUS_BAD_CMD 8'h02
`define CCAM_PARAM_TARGET_POS 8'h00
`define CCAM_STACK_DEPTH 8
`define CCAM_COND_LAST 4'hB
`define CCAM_MOVE_LAST 8'h02
`define CCAM_AXIS_COUNT 6
`endif

// ### ccam_pkg.sv
// Types for the conditional call and accumulator move interpreter slice
package ccam_pkg;
  typedef enum logic [3:0] {
    cond_zero = 4'h0,
    cond_not_zero = 4'h1,
    cond_equal = 4'h2,
    cond_not_equal = 4'h3,
    cond_greater = 4'h4,
    cond_greater_equal = 4'h5,
    cond_lower = 4'h6,
    cond_lower_equal = 4'h7,
    cond_timeout_error = 4'h8,
    cond_external_alarm = 4'h9,
    cond_deviation_error = 4'hA,
    cond_position_error = 4'hB
  } ccam_cond_e;
  typedef enum logic [1:0] {
    move_type_absolute = 2'h0,
    move_type_relative = 2'h1,
    move_type_stored_coordinate = 2'h2
  } ccam_move_e;
  typedef enum logic [1:0] {
    CCAM_IDLE = 2'h0,
    CCAM_MOVE_TYPE_STORED_COORDINATE_WAIT = 2'h1,
    CCAM_REPLY = 2'h2
  } ccam_state_e;
endpackage

// ### ccam_return_stack.sv
// Bounded return stack of program counters
`timescale 1ns/1ps
`include "ccam_params.svh"
module ccam_return_stack import ccam_pkg::*; #(
  parameter int DEPTH = `CCAM_STACK_DEPTH,
  parameter int PC_W = 32
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Operations, one at a time
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic clear_in,
  input wire logic [PC_W-1:0] push_data_in,
  // State
  output logic [PC_W-1:0] top_out,
  output logic full_out,
  output logic empty_out
);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] mem;
    logic [CW-1:0] count;
  } ccam_stk_s;
  ccam_stk_s st;
  ccam_stk_s next_st;

  assign full_out = (st.count == CW'(DEPTH));
  assign empty_out = (st.count == '0);
  assign top_out = empty_out ? '0 : st.mem[st.count - CW'(1)];

  always_comb begin
    next_st = st;
    if (clear_in) begin
      next_st.count = '0;
    end else if (push_in && !full_out) begin
      next_st.mem[st.count] = push_data_in;
      next_st.count = st.count + CW'(1);
    end else if (pop_in && !empty_out) begin
      next_st.count = st.count - CW'(1);
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
